// file: common/cmdsel_pkg.sv
// Constants and types for the command source selector
package cmdsel_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CMDSEL_ADDR_SERIAL  = 4'h0;
  localparam logic [3:0] CMDSEL_ADDR_BUS     = 4'h1;
  localparam logic [3:0] CMDSEL_ADDR_CAN     = 4'h2;
  localparam logic [3:0] CMDSEL_ADDR_TERM    = 4'h3;
  localparam logic [3:0] CMDSEL_ADDR_INTERN  = 4'h4;
  localparam logic [3:0] CMDSEL_ADDR_STATUS  = 4'h5;
  localparam logic [3:0] CMDSEL_ADDR_TERM_HI = 4'h6;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CMDSEL_SERIAL_MAX   = 4'h8;
  localparam logic [1:0] CMDSEL_BUS_RST      = 2'h0;
  localparam logic [3:0] CMDSEL_SERIAL_RST   = 4'h0;
  localparam logic [7:0] CMDSEL_FN_GATE      = 8'h18;  // 24
  localparam logic [7:0] CMDSEL_FN_DROOP     = 8'h4C;  // 76
  localparam int         CMDSEL_N_TERM       = 5;

  // Source selected for one command
  typedef enum logic [2:0] {
    CMDSEL_SRC_INTERNAL,
    CMDSEL_SRC_PORT1,
    CMDSEL_SRC_PORT2,
    CMDSEL_SRC_FIELDBUS,
    CMDSEL_SRC_CAN
  } cmdsel_src_t;

endpackage : cmdsel_pkg

// file: rtl/cmdsel_top.sv
// Command source selector: frequency and run source muxing plus droop
//
// The address map and the strobed register port were chosen for this implementation.
module cmdsel_top
  import cmdsel_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              NRST_IN,
  input  wire logic [3:0]        ADDR_IN,
  input  wire logic [31:0]       WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [31:0]       RDATA_OUT,
  input  wire logic [4:0]        TERM_IN,
  input  wire logic [FREQ_W-1:0] FREQ_SETTING_IN,
  input  wire logic [FREQ_W-1:0] FREQ_MULTISTEP_IN,
  input  wire logic              MULTISTEP_SEL_IN,
  input  wire logic [FREQ_W-1:0] FREQ_PORT1_IN,
  input  wire logic [FREQ_W-1:0] FREQ_PORT2_IN,
  input  wire logic [FREQ_W-1:0] FREQ_FIELDBUS_IN,
  input  wire logic [FREQ_W-1:0] FREQ_CAN_IN,
  input  wire logic [FREQ_W-1:0] FREQ_DROOP_IN,
  input  wire logic              RUN_KEYPAD_IN,
  input  wire logic              RUN_TERMINAL_IN,
  input  wire logic              RUN_PORT1_IN,
  input  wire logic              RUN_PORT2_IN,
  input  wire logic              RUN_FIELDBUS_IN,
  input  wire logic              RUN_CAN_IN,
  output logic      [FREQ_W-1:0] FREQ_CMD_OUT,
  output logic                   RUN_CMD_OUT,
  output logic      [2:0]        FREQ_SRC_OUT,
  output logic      [2:0]        RUN_SRC_OUT,
  output logic                   DROOP_EN_OUT,
  output logic                   RAMP_DROOP_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]        serial_source_code;
    logic [1:0]        fieldbus_source_code;
    logic              can_enable_code;
    logic [CMDSEL_N_TERM-1:0][7:0] input_terminal_function_codes;
    logic [1:0]        internal_freq_source_setting;
    logic              internal_run_method_setting;
    logic              vf_mode;
    logic [4:0]        term_meta;
    logic [4:0]        term_sync;
    logic [31:0]       rdata;
    logic [FREQ_W-1:0] freq;
    logic              run;
    logic [2:0]        fsrc;
    logic [2:0]        rsrc;
    logic              droop;
    logic              ramp_droop;
  } cmdsel_state_t;

  cmdsel_state_t state_reg;
  cmdsel_state_t state_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic fn_active(
    input logic [CMDSEL_N_TERM-1:0][7:0] fn,
    input logic [4:0] lvl, input logic [7:0] code, input logic dflt);
    logic hit;
    logic act;
    hit = 1'b0;
    act = 1'b0;
    for (int i = 0; i < CMDSEL_N_TERM; i++) begin
      if (fn[i] == code) begin
        hit = 1'b1;
        act = act | lvl[i];
      end
    end
    return hit ? act : dflt;
  endfunction

  // Serial code to {freq source, run source}
  function automatic logic [5:0] fn_serial(input logic [3:0] code);
    case (code)
      4'h1:    return {CMDSEL_SRC_PORT1, CMDSEL_SRC_INTERNAL};
      4'h2:    return {CMDSEL_SRC_INTERNAL, CMDSEL_SRC_PORT1};
      4'h3:    return {CMDSEL_SRC_PORT1, CMDSEL_SRC_PORT1};
      4'h4:    return {CMDSEL_SRC_PORT2, CMDSEL_SRC_INTERNAL};
      4'h5:    return {CMDSEL_SRC_PORT2, CMDSEL_SRC_PORT1};
      4'h6:    return {CMDSEL_SRC_INTERNAL, CMDSEL_SRC_PORT2};
      4'h7:    return {CMDSEL_SRC_PORT1, CMDSEL_SRC_PORT2};
      4'h8:    return {CMDSEL_SRC_PORT2, CMDSEL_SRC_PORT2};
      default: return {CMDSEL_SRC_INTERNAL, CMDSEL_SRC_INTERNAL};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        gate;
    logic [5:0]  ser;
    cmdsel_src_t bus_src;
    cmdsel_src_t fs;
    cmdsel_src_t rs;
    logic        int_run;
    logic [FREQ_W-1:0] int_freq;
    gate     = 1'b0;
    ser      = 6'h00;
    bus_src  = CMDSEL_SRC_FIELDBUS;
    fs       = CMDSEL_SRC_INTERNAL;
    rs       = CMDSEL_SRC_INTERNAL;
    int_run  = 1'b0;
    int_freq = '0;
    state_next = state_reg;
    state_next.term_meta = TERM_IN;
    state_next.term_sync = state_reg.term_meta;

    // Register writes; serial codes above 8 are refused, keep last value
    if (WR_IN) begin
      case (ADDR_IN)
        CMDSEL_ADDR_SERIAL:
          if (WDATA_IN[3:0] <= CMDSEL_SERIAL_MAX && WDATA_IN[31:4] == '0)
            state_next.serial_source_code = WDATA_IN[3:0];
        CMDSEL_ADDR_BUS: state_next.fieldbus_source_code = WDATA_IN[1:0];
        CMDSEL_ADDR_CAN: state_next.can_enable_code = WDATA_IN[0];
        // Five code bytes do not fit one word: terminal 5 sits alone
        CMDSEL_ADDR_TERM:
          state_next.input_terminal_function_codes[3:0] = WDATA_IN;
        CMDSEL_ADDR_TERM_HI:
          state_next.input_terminal_function_codes[4] = WDATA_IN[7:0];
        CMDSEL_ADDR_INTERN: begin
          state_next.internal_freq_source_setting = WDATA_IN[1:0];
          state_next.internal_run_method_setting  = WDATA_IN[2];
          state_next.vf_mode                      = WDATA_IN[3];
        end
        default: ;
      endcase
    end

    state_next.rdata = 32'h0000_0000;
    if (RD_IN) begin
      case (ADDR_IN)
        CMDSEL_ADDR_SERIAL:
          state_next.rdata[3:0] = state_reg.serial_source_code;
        CMDSEL_ADDR_BUS:
          state_next.rdata[1:0] = state_reg.fieldbus_source_code;
        CMDSEL_ADDR_CAN:  state_next.rdata[0]   = state_reg.can_enable_code;
        CMDSEL_ADDR_TERM:
          state_next.rdata = state_reg.input_terminal_function_codes[3:0];
        CMDSEL_ADDR_TERM_HI:
          state_next.rdata[7:0] = state_reg.input_terminal_function_codes[4];
        CMDSEL_ADDR_INTERN:
          state_next.rdata[3:0] = {state_reg.vf_mode,
                                   state_reg.internal_run_method_setting,
                                   state_reg.internal_freq_source_setting};
        CMDSEL_ADDR_STATUS:
          state_next.rdata[8:0] = {state_reg.ramp_droop, state_reg.droop,
                                   state_reg.run, state_reg.rsrc,
                                   state_reg.fsrc};
        default: ;
      endcase
    end

    // Remote gate; unassigned counts as on
    gate = fn_active(state_reg.input_terminal_function_codes,
                     state_reg.term_sync, CMDSEL_FN_GATE, 1'b1);
    ser  = fn_serial(state_reg.serial_source_code);
    bus_src = state_reg.can_enable_code ? CMDSEL_SRC_CAN
                                        : CMDSEL_SRC_FIELDBUS;
    fs = cmdsel_src_t'(ser[5:3]);
    rs = cmdsel_src_t'(ser[2:0]);
    if (state_reg.fieldbus_source_code[0]) fs = bus_src;
    if (state_reg.fieldbus_source_code[1]) rs = bus_src;
    if (!gate) begin
      fs = CMDSEL_SRC_INTERNAL;
      rs = CMDSEL_SRC_INTERNAL;
    end

    int_run  = state_reg.internal_run_method_setting ? RUN_TERMINAL_IN
                                                     : RUN_KEYPAD_IN;
    int_freq = MULTISTEP_SEL_IN ? FREQ_MULTISTEP_IN : FREQ_SETTING_IN;

    case (fs)
      CMDSEL_SRC_PORT1:    state_next.freq = FREQ_PORT1_IN;
      CMDSEL_SRC_PORT2:    state_next.freq = FREQ_PORT2_IN;
      CMDSEL_SRC_FIELDBUS: state_next.freq = FREQ_FIELDBUS_IN;
      CMDSEL_SRC_CAN:      state_next.freq = FREQ_CAN_IN;
      default:             state_next.freq = int_freq;
    endcase
    case (rs)
      CMDSEL_SRC_PORT1:    state_next.run = RUN_PORT1_IN;
      CMDSEL_SRC_PORT2:    state_next.run = RUN_PORT2_IN;
      CMDSEL_SRC_FIELDBUS: state_next.run = RUN_FIELDBUS_IN;
      CMDSEL_SRC_CAN:      state_next.run = RUN_CAN_IN;
      default:             state_next.run = int_run;
    endcase
    state_next.fsrc = fs;
    state_next.rsrc = rs;

    // Droop terminal; no assignment means droop stays off
    state_next.droop = fn_active(state_reg.input_terminal_function_codes,
                       state_reg.term_sync, CMDSEL_FN_DROOP, 1'b0);
    // V/f: droop result feeds the ramp, avoiding trips on load steps
    state_next.ramp_droop = state_next.droop & state_reg.vf_mode;
    if (state_next.ramp_droop) state_next.freq = FREQ_DROOP_IN;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!NRST_IN) begin
      state_reg <= '0;
      state_reg.serial_source_code   <= CMDSEL_SERIAL_RST;
      state_reg.fieldbus_source_code <= CMDSEL_BUS_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign RDATA_OUT      = state_reg.rdata;
  assign FREQ_CMD_OUT   = state_reg.freq;
  assign RUN_CMD_OUT    = state_reg.run;
  assign FREQ_SRC_OUT   = state_reg.fsrc;
  assign RUN_SRC_OUT    = state_reg.rsrc;
  assign DROOP_EN_OUT   = state_reg.droop;
  assign RAMP_DROOP_OUT = state_reg.ramp_droop;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  function automatic logic gate_on();
    return fn_active(state_reg.input_terminal_function_codes,
                     state_reg.term_sync, CMDSEL_FN_GATE, 1'b1);
  endfunction

  sequence s_bus_both;
    gate_on() && state_reg.fieldbus_source_code == 2'h3;
  endsequence

  property p_droop;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    (state_reg.input_terminal_function_codes[0] == CMDSEL_FN_DROOP &&
     state_reg.term_sync[0]) |=> DROOP_EN_OUT;
  endproperty
  a_droop: assert property (p_droop) else $error("droop not enabled");

  property p_ramp;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    RAMP_DROOP_OUT == (DROOP_EN_OUT && $past(state_reg.vf_mode));
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp flag wrong");

  property p_ser3;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    (gate_on() && state_reg.serial_source_code == 4'h3 &&
     state_reg.fieldbus_source_code == 2'h0) |=>
      (FREQ_SRC_OUT == CMDSEL_SRC_PORT1 && RUN_SRC_OUT == CMDSEL_SRC_PORT1);
  endproperty
  a_ser3: assert property (p_ser3) else $error("code 3 misrouted");

  property p_ser7;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    (gate_on() && state_reg.serial_source_code == 4'h7 &&
     state_reg.fieldbus_source_code == 2'h0) |=>
      (FREQ_SRC_OUT == CMDSEL_SRC_PORT1 && RUN_SRC_OUT == CMDSEL_SRC_PORT2);
  endproperty
  a_ser7: assert property (p_ser7) else $error("code 7 misrouted");

  property p_bus;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    s_bus_both |=> (FREQ_SRC_OUT >= CMDSEL_SRC_FIELDBUS &&
                    RUN_SRC_OUT >= CMDSEL_SRC_FIELDBUS);
  endproperty
  a_bus: assert property (p_bus) else $error("bus code ignored");

  property p_can;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    (gate_on() && state_reg.can_enable_code &&
     state_reg.fieldbus_source_code[0]) |=> FREQ_SRC_OUT == CMDSEL_SRC_CAN;
  endproperty
  a_can: assert property (p_can) else $error("CAN not swapped in");

  property p_gate;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    !gate_on() |=> (FREQ_SRC_OUT == CMDSEL_SRC_INTERNAL &&
                    RUN_SRC_OUT == CMDSEL_SRC_INTERNAL);
  endproperty
  a_gate: assert property (p_gate) else $error("gate off ignored");

  property p_int_run;
    @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
    (!gate_on() && state_reg.internal_run_method_setting) |=>
      RUN_CMD_OUT == $past(RUN_TERMINAL_IN);
  endproperty
  a_int_run: assert property (p_int_run) else $error("bad run");

endmodule // cmdsel_top

// file: bench/cmdsel_remote.sv
// Remote controller model driving the link-side command levels
module cmdsel_remote
  import cmdsel_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  input  wire logic              clk_in,
  input  wire logic [31:0]       word_in,
  output logic      [FREQ_W-1:0] freq_port1_out,
  output logic      [FREQ_W-1:0] freq_port2_out,
  output logic      [FREQ_W-1:0] freq_bus_out,
  output logic      [FREQ_W-1:0] freq_can_out,
  output logic      [3:0]        run_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // New command set each cycle: stale values would hide a wrong source
  always_ff @(posedge clk_in) begin
    freq_port1_out <= FREQ_W'(word_in);
    freq_port2_out <= FREQ_W'(word_in >> 16);
    freq_bus_out   <= FREQ_W'(~word_in);
    freq_can_out   <= FREQ_W'({word_in[7:0], word_in[31:24]});
    run_out        <= word_in[19:16] ^ word_in[3:0];
  end
endmodule // cmdsel_remote

// file: bench/tb.sv
// Self-checking testbench for the command source selector
module tb import cmdsel_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, ms = 0, rkp = 0, rtm = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, rw = 32'h0000_0000, x, r, iv;
  logic [4:0] term = 5'h00;
  logic [15:0] fset = 16'h0000, fms = 16'h0000, fdr = 16'h0000;
  logic [15:0] f1, f2, fb, fc, fcmd;
  logic [3:0] rr;
  logic [2:0] fsrc, rsrc, es_f, es_r;
  logic rcmd, droop, ramp;
  logic [2:0] sf [9] = '{0, 1, 0, 1, 2, 2, 0, 1, 2};
  logic [2:0] sr [9] = '{0, 0, 1, 1, 0, 1, 2, 2, 2};
  int n_mismatch = 0, n_tests = 0, cyc = 0, g, t;
  always #4 clk = ~clk;
  cmdsel_top dut (.SYS_CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .TERM_IN(term), .FREQ_SETTING_IN(fset), .FREQ_MULTISTEP_IN(fms),
    .MULTISTEP_SEL_IN(ms), .FREQ_PORT1_IN(f1), .FREQ_PORT2_IN(f2),
    .FREQ_FIELDBUS_IN(fb), .FREQ_CAN_IN(fc), .FREQ_DROOP_IN(fdr),
    .RUN_KEYPAD_IN(rkp), .RUN_TERMINAL_IN(rtm), .RUN_PORT1_IN(rr[0]),
    .RUN_PORT2_IN(rr[1]), .RUN_FIELDBUS_IN(rr[2]), .RUN_CAN_IN(rr[3]),
    .FREQ_CMD_OUT(fcmd), .RUN_CMD_OUT(rcmd), .FREQ_SRC_OUT(fsrc),
    .RUN_SRC_OUT(rsrc), .DROOP_EN_OUT(droop), .RAMP_DROOP_OUT(ramp));
  cmdsel_remote remote (.clk_in(clk), .word_in(rw), .freq_port1_out(f1),
    .freq_port2_out(f2), .freq_bus_out(fb), .freq_can_out(fc),
    .run_out(rr));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [15:0] efreq(input logic [2:0] s);
    case (s)
      3'h1: return f1;
      3'h2: return f2;
      3'h3: return fb;
      3'h4: return fc;
      default: return ms ? fms : fset;
    endcase
  endfunction
  function automatic logic erun(input logic [2:0] s);
    case (s)
      3'h1: return rr[0];
      3'h2: return rr[1];
      3'h3: return rr[2];
      3'h4: return rr[3];
      default: return iv[2] ? rtm : rkp;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    x = 32'h32b9_4338;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk({fsrc, rsrc, droop}, 32'h0000_0000);
    for (int s = 0; s < 9; s++) for (int b = 0; b < 4; b++)
      for (int c = 0; c < 2; c++) begin
        x = xs(x); g = x % 3; t = (x >> 4) % 4;
        x = xs(x); iv = x & 32'h0000_0007;
        wreg(CMDSEL_ADDR_SERIAL, s);
        wreg(CMDSEL_ADDR_BUS, b);
        wreg(CMDSEL_ADDR_CAN, c);
        wreg(CMDSEL_ADDR_TERM, g == 0 ? 32'h0 : 32'h0000_0018 << (8 * t));
        wreg(CMDSEL_ADDR_INTERN, iv);
        x = xs(x); r = x; x = xs(x);
        @(posedge clk);
        fset <= r[15:0]; fms <= r[31:16]; ms <= r[5];
        rkp <= r[6]; rtm <= r[7]; rw <= x;
        // Gate terminal forced to the wanted level, others random
        term <= g == 2 ? r[12:8] & ~(5'h01 << t) : r[12:8] | (5'h01 << t);
        repeat (6) @(posedge clk);
        #1;
        es_f = g == 2 ? 3'h0 : b[0] ? (c ? 3'h4 : 3'h3) : sf[s];
        es_r = g == 2 ? 3'h0 : b[1] ? (c ? 3'h4 : 3'h3) : sr[s];
        chk(fsrc, es_f);
        chk(rsrc, es_r);
        chk(fcmd, efreq(es_f));
        chk(rcmd, erun(es_r));
        rreg(CMDSEL_ADDR_STATUS, r);
        chk(r, {23'h0, 2'b00, erun(es_r), es_r, es_f});
      end
    wreg(CMDSEL_ADDR_SERIAL, 32'h0000_0009);
    rreg(CMDSEL_ADDR_SERIAL, r);
    chk(r, 32'h0000_0008);
    rreg(4'hF, r);
    chk(r, 32'h0000_0000);
    // Droop on terminal 1 under V/f, gate on terminal 2
    wreg(CMDSEL_ADDR_TERM, 32'h0000_184C);
    wreg(CMDSEL_ADDR_INTERN, 32'h0000_0008);
    rreg(CMDSEL_ADDR_TERM, r);
    chk(r, 32'h0000_184C);
    @(posedge clk);
    fdr <= 16'hA5C3;
    term <= 5'h03;
    repeat (6) @(posedge clk);
    #1 chk({droop, ramp}, 2'b11);
    chk(fcmd, 16'hA5C3);
    @(posedge clk);
    term <= 5'h02;
    repeat (6) @(posedge clk);
    #1 chk({droop, ramp}, 2'b00);
    // Terminal 5 code byte lives at its own offset
    wreg(CMDSEL_ADDR_TERM_HI, 32'h0000_0018);
    rreg(CMDSEL_ADDR_TERM_HI, r);
    chk(r, 32'h0000_0018);
    test_done();
  end
endmodule // tb
